//--- design/hpb_pkg.sv
`default_nettype none

package hpb_pkg;

    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int HPB_AW = 12;
    localparam int HPB_DW = 16;
    localparam int HPB_IRQ_W = 8;

    // ----------------------------------------
    // Synchroniser and reset values
    // ----------------------------------------
    localparam int HPB_SYNC_STAGES = 3;
    localparam logic [2:0] HPB_SYNC_RST = 3'h7;
    localparam logic [HPB_DW-1:0] HPB_DATA_RST = 16'h0000;

    // ----------------------------------------
    // Strobe style and access states
    // ----------------------------------------
    typedef enum logic {
        HPB_STYLE_DIR = 1'b0,
        HPB_STYLE_SEP = 1'b1
    } hpb_style_e;

    typedef enum logic [2:0] {
        HPB_ST_IDLE  = 3'b001,
        HPB_ST_READ  = 3'b010,
        HPB_ST_WRITE = 3'b100
    } hpb_state_e;

endpackage : hpb_pkg

`default_nettype wire

//--- design/hpb_sync.sv
`default_nettype none

// Three-stage pin synchroniser; a change is accepted once stages two and three agree.
module hpb_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] pin_in,
    output var logic [W-1:0] sync_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_d;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            assign out_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : sync_out[g];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            sync_out <= out_d;
        end
    end
endmodule // hpb_sync

`default_nettype wire

//--- design/hpb_port.sv
`default_nettype none

// Overview of operation
// - Chip select high: ignore all bus signals
// - Direction line low writes, high reads
// - Separate style: capture data during write low
// - Separate style: drive data while read low
// - Pull interrupt low while any condition pending
// - Decode all twelve address bits
// - Drive data bus only during reads
module hpb_port #(
    parameter int AW = hpb_pkg::HPB_AW,
    parameter int DW = hpb_pkg::HPB_DW,
    parameter int IW = hpb_pkg::HPB_IRQ_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic style_sep,
    input wire logic host_cs_n,
    input wire logic host_rw_wr_n,
    input wire logic host_oe_rd_n,
    input wire logic [AW-1:0] host_addr,
    input wire logic [DW-1:0] host_data_in,
    output logic [DW-1:0] host_data_out,
    output logic host_data_oe_n,
    output logic host_irq_out,
    output logic host_irq_oe_n,
    input wire logic [IW-1:0] irq_pending,
    output logic [AW-1:0] loc_addr,
    output logic loc_wr,
    output logic [DW-1:0] loc_wdata,
    output logic loc_rd,
    input wire logic [DW-1:0] loc_rdata
);
    import hpb_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Address and data pass the same three stages as the strobes, so all of them
    // reach the access logic on the same edge and a strobe never outruns its data.
    logic [2:0] ctl_s;
    logic [AW-1:0] addr_s;
    logic [DW-1:0] data_s;

    hpb_sync #(.W(3), .RST_VAL(HPB_SYNC_RST)) u_sync_ctl (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in({host_cs_n, host_rw_wr_n, host_oe_rd_n}),
        .sync_out(ctl_s)
    );

    hpb_sync #(.W(AW), .RST_VAL('0)) u_sync_addr (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in(host_addr),
        .sync_out(addr_s)
    );

    hpb_sync #(.W(DW), .RST_VAL('0)) u_sync_data (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in(host_data_in),
        .sync_out(data_s)
    );

    // ----------------------------------------
    // Style latch and strobe decode
    // ----------------------------------------
    // The style is taken once after reset; later changes of the strap are ignored.
    logic style_q;
    logic style_taken_q;
    logic sel_w;
    logic rd_req_w;
    logic wr_req_w;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            style_q <= 1'b0;
            style_taken_q <= 1'b0;
        end else if (!style_taken_q) begin
            style_q <= style_sep;
            style_taken_q <= 1'b1;
        end
    end

    assign sel_w = style_taken_q && !ctl_s[2];
    // Direction style: the output-enable pin is tied low by the host and not consulted.
    assign rd_req_w = sel_w && (style_q ? !ctl_s[0] : ctl_s[1]);
    assign wr_req_w = sel_w && (style_q ? !ctl_s[1] : !ctl_s[1]);

    // ----------------------------------------
    // Access state machine
    // ----------------------------------------
    hpb_state_e state_q;
    hpb_state_e state_d;

    // Write wins when both strobes are low at once; a read would otherwise
    // return data that the write is about to change.
    always_comb begin
        state_d = state_q;
        case (state_q)
            HPB_ST_IDLE: begin
                if (wr_req_w) begin
                    state_d = HPB_ST_WRITE;
                end else if (rd_req_w) begin
                    state_d = HPB_ST_READ;
                end
            end
            HPB_ST_READ: begin
                if (!rd_req_w) begin
                    state_d = HPB_ST_IDLE;
                end
            end
            HPB_ST_WRITE: begin
                if (!wr_req_w) begin
                    state_d = HPB_ST_IDLE;
                end
            end
            default: begin
                state_d = HPB_ST_IDLE;
            end
        endcase
    end

    wire rd_start_w = (state_q == HPB_ST_IDLE) && (state_d == HPB_ST_READ);
    // The write is issued once the low phase ends, with data from its last low sample, so the host's late data is caught.
    wire wr_end_w = (state_q == HPB_ST_WRITE) && !wr_req_w;
    wire in_read_w = (state_q == HPB_ST_READ) && rd_req_w;
    wire irq_any_w = |irq_pending;

    // ----------------------------------------
    // Next-value selection
    // ----------------------------------------
    // The address is taken once, as an access opens, so a host that moves the
    // address bus late in its strobe cannot redirect a transfer half way.
    logic addr_take_w;
    logic wdata_take_w;
    logic [AW-1:0] loc_addr_d;
    logic [DW-1:0] loc_wdata_d;
    logic [DW-1:0] host_data_out_d;
    logic host_data_oe_n_d;
    logic host_irq_oe_n_d;

    assign addr_take_w = rd_start_w || ((state_q == HPB_ST_IDLE) && wr_req_w);
    // Write data is refreshed only while the strobe still holds: the sample that
    // shows the strobe released may already carry the host's next bus value.
    assign wdata_take_w = (state_q == HPB_ST_WRITE) && wr_req_w;
    assign loc_addr_d = addr_take_w ? addr_s : loc_addr;
    assign loc_wdata_d = wdata_take_w ? data_s : loc_wdata;
    assign host_data_out_d = in_read_w ? loc_rdata : host_data_out;
    assign host_data_oe_n_d = !in_read_w;
    assign host_irq_oe_n_d = !irq_any_w;

    // ----------------------------------------
    // Access state register
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= HPB_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // Internal access strobes
    // ----------------------------------------
    // Each strobe is a single-cycle pulse, so the internal side never sees one
    // host access twice however long the host holds its strobe.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loc_wr <= 1'b0;
            loc_rd <= 1'b0;
        end else begin
            loc_wr <= wr_end_w;
            loc_rd <= rd_start_w;
        end
    end

    // ----------------------------------------
    // Internal address and write data
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loc_addr <= '0;
            loc_wdata <= HPB_DATA_RST;
        end else begin
            loc_addr <= loc_addr_d;
            loc_wdata <= loc_wdata_d;
        end
    end

    // ----------------------------------------
    // Host data bus driver
    // ----------------------------------------
    // The enable is a flop of its own so the bus is released on a clean edge;
    // the cost is one more cycle before the bus is let go after a read.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            host_data_out <= HPB_DATA_RST;
            host_data_oe_n <= 1'b1;
        end else begin
            host_data_out <= host_data_out_d;
            host_data_oe_n <= host_data_oe_n_d;
        end
    end

    // ----------------------------------------
    // Interrupt line
    // ----------------------------------------
    // The line is open drain: the value is always low and only the enable moves.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            host_irq_out <= 1'b0;
            host_irq_oe_n <= 1'b1;
        end else begin
            host_irq_out <= 1'b0;
            host_irq_oe_n <= host_irq_oe_n_d;
        end
    end
endmodule // hpb_port

`default_nettype wire

//--- test/hpb_port_asserts.sv
`default_nettype none
module hpb_port_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic host_cs_n,
    input wire logic host_data_oe_n,
    input wire logic host_irq_out,
    input wire logic host_irq_oe_n,
    input wire logic [7:0] irq_pending,
    input wire logic loc_wr,
    input wire logic loc_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_irq_tracks: assert property (
        !$past(sys_rst) |-> host_irq_oe_n == ~|$past(irq_pending)) else $error("irq");
    a_irq_low: assert property (host_irq_out == 1'b0) else $error("irq");
    a_cs_quiet: assert property (
        host_cs_n [*8] |-> !loc_wr && !loc_rd && host_data_oe_n) else $error("cs");
    a_rd_pulse: assert property (loc_rd |=> !loc_rd) else $error("rd");
    a_wr_pulse: assert property (loc_wr |=> !loc_wr) else $error("wr");
    a_drive_cause: assert property (
        $fell(host_data_oe_n) |-> $past(loc_rd)) else $error("drive");
    a_wr_quiet: assert property (loc_wr |-> host_data_oe_n) else $error("wr");
    a_one_dir: assert property (!(loc_wr && loc_rd)) else $error("dir");
    cover property (loc_wr);
    cover property (loc_rd);
    cover property ($fell(host_irq_oe_n));
endmodule // hpb_port_asserts
`default_nettype wire

//--- test/hpb_host_model.sv
`default_nettype none
module hpb_host_model (
    input wire logic clk,
    input wire logic sep,
    input wire logic [15:0] dout,
    input wire logic oen,
    output logic cs_n,
    output logic rw,
    output logic oe,
    output logic [11:0] a,
    output logic [15:0] din
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv = 1'b0;
    logic [15:0] wd = 16'h0000;
    // An undriven bus shows the inverse, so stale data never passes.
    assign din = drv ? wd : (oen ? ~dout : dout);
    initial begin
        {cs_n, rw} = 2'h3;
        oe = sep;
        a = 12'h000;
    end
    task automatic acc(logic s, logic w, logic [11:0] ad, logic [15:0] d, output logic [15:0] q);
        @(posedge clk);
        cs_n <= !s;
        a <= ad;
        wd <= d;
        drv <= w;
        rw <= !w;
        oe <= sep ? w : 1'b0;
        repeat (12) @(posedge clk);
        q = din;
        {cs_n, rw, oe, drv} <= {2'h3, sep, 1'b0};
        repeat (12) @(posedge clk);
    endtask
endmodule // hpb_host_model
`default_nettype wire

//--- test/hpb_port_tb_top.sv
`default_nettype none
module hpb_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, sys_rst = 1'b1, sep = 1'b0, cs_n, rw, oe, oen, io, ion, wr, rd;
    logic [7:0] irq = 8'h00;
    logic [11:0] a, la;
    logic [15:0] din, dout, wd, q;
    logic [15:0] mem [4096];
    int failures = 0, tests_run = 0;
    initial forever #10 clk = ~clk;
    always @(posedge clk) if (wr) mem[la] <= wd;
    hpb_port dut (.clk(clk), .sys_rst(sys_rst), .style_sep(sep), .host_cs_n(cs_n),
        .host_rw_wr_n(rw), .host_oe_rd_n(oe), .host_addr(a), .host_data_in(din),
        .host_data_out(dout), .host_data_oe_n(oen), .host_irq_out(io), .host_irq_oe_n(ion),
        .irq_pending(irq), .loc_addr(la), .loc_wr(wr), .loc_wdata(wd), .loc_rd(rd),
        .loc_rdata(mem[la]));
    hpb_host_model host (.clk(clk), .sep(sep), .dout(dout), .oen(oen), .cs_n(cs_n), .rw(rw),
        .oe(oe), .a(a), .din(din));
    task automatic chk(string n, logic [15:0] g, logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic t_rw(logic s, logic [15:0] d);
        @(posedge clk);
        {sys_rst, sep} <= {1'b1, s};
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        host.acc(1'b1, 1'b1, 12'h001, d, q);
        host.acc(1'b1, 1'b1, 12'h801, ~d, q);
        host.acc(1'b0, 1'b1, 12'h801, d, q);
        host.acc(1'b1, 1'b0, 12'h001, d, q);
        chk("low", q, d);
        host.acc(1'b1, 1'b0, 12'h801, d, q);
        chk("high", q, ~d);
        chk("release", {15'h0, oen}, 16'h1);
    endtask
    task automatic t_irq;
        irq <= 8'h80;
        repeat (3) @(posedge clk);
        chk("irq on", {14'h0, io, ion}, 16'h0);
        irq <= 8'h00;
        repeat (3) @(posedge clk);
        chk("irq off", {14'h0, io, ion}, 16'h1);
        irq <= 8'h01;
        repeat (3) @(posedge clk);
        chk("irq bit0", {14'h0, io, ion}, 16'h0);
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        t_rw(1'b0, 16'h1234);
        t_rw(1'b1, 16'hc3a5);
        t_irq;
        end_sim;
    end
    initial begin
        repeat (2000) @(posedge clk);
        failures++;
        end_sim;
    end
endmodule // hpb_port_tb_top
bind hpb_port hpb_port_asserts chk (.clk, .sys_rst, .host_cs_n, .host_data_oe_n,
    .host_irq_out, .host_irq_oe_n, .irq_pending, .loc_wr, .loc_rd);
`default_nettype wire
